// File: dprs_pkg.sv
// Constants for the drive protection and restart supervisor.
// Assumes a 50 MHz system clock and APB register access.
package dprs_pkg;
  // Clock rate and time bases
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned DEB_UNIT_MS   = 2;
  localparam int unsigned TENTH_SEC_MS  = 100;
  localparam int unsigned DEB_UNIT_CYC  = CLK_HZ / 1000 * DEB_UNIT_MS;
  localparam int unsigned TENTH_CYC     = CLK_HZ / 1000 * TENTH_SEC_MS;
  // Byte offsets of the setting and status registers
  localparam logic [7:0] OFS_THERM_DEB  = 8'h00;
  localparam logic [7:0] OFS_THERM_LVL  = 8'h04;
  localparam logic [7:0] OFS_THERM_CTL  = 8'h08;
  localparam logic [7:0] OFS_BRAKE      = 8'h0C;
  localparam logic [7:0] OFS_BRAKE_FREQ = 8'h10;
  localparam logic [7:0] OFS_LOSS       = 8'h14;
  localparam logic [7:0] OFS_SEARCH     = 8'h18;
  localparam logic [7:0] OFS_SKIP1      = 8'h1C;
  localparam logic [7:0] OFS_SKIP2      = 8'h20;
  localparam logic [7:0] OFS_SKIP3      = 8'h24;
  localparam logic [7:0] OFS_RESTART    = 8'h28;
  localparam logic [7:0] OFS_STATUS     = 8'h2C;
  // Reset values (tenths of volts, tenths of seconds, units)
  localparam logic [13:0] RST_DEB       = 14'h0064;
  localparam logic [6:0]  RST_TRIP      = 7'h18;
  localparam logic [6:0]  RST_WARN      = 7'h0C;
  localparam logic [5:0]  RST_HYST      = 6'h06;
  localparam logic [1:0]  RST_TREAT     = 2'h0;
  localparam logic [5:0]  RST_LOSS_T    = 6'h14;
  localparam logic [1:0]  RST_BB_SEL    = 2'h1;
  localparam logic [5:0]  RST_BB_T      = 6'h05;
  localparam logic [7:0]  RST_SRCH_I    = 8'h96;
  localparam logic [15:0] RST_REFILL    = 16'h0258;
  localparam logic [5:0]  LOSS_LIMIT    = 6'h32;
  // Supervisor states
  typedef enum logic [2:0] {
    DP_IDLE, DP_STARTBRAKE, DP_RUN, DP_STOPPING, DP_STOPBRAKE,
    DP_BLOCKWAIT, DP_SEARCH, DP_FAULTED
  } dprs_state_type;
endpackage

// File: dprs_supervisor.sv
// Drive protection and restart supervisor: thermistor overheat, DC brake,
// power-loss timer but no ride-through entry (lossArmed is never high while uvPrev is low), base-block speed search, skip bands, restart.
// Assumes the command, fault and thermistor inputs come from pins and are synchronised here; current and frequency inputs are not.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module dprs_supervisor #(
  parameter int unsigned TENTH_CYCLES = dprs_pkg::TENTH_CYC,
  parameter int unsigned DEB_CYCLES   = dprs_pkg::DEB_UNIT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  analogVoltageInput,
  input  wire logic        runCommand,
  input  wire logic        resetKey,
  input  wire logic        undervoltageIndication,
  input  wire logic        overloadTrip,
  input  wire logic        externalBlock,
  input  wire logic        overCurrentFault,
  input  wire logic        overVoltageFault,
  input  wire logic [7:0]  outputCurrentPct,
  input  wire logic [15:0] outputFreq,
  input  wire logic [15:0] masterFreq,
  input  wire logic [15:0] minFreq,
  input  wire logic [15:0] requestFreq,
  output logic             outputBlock,
  output logic             coastStop,
  output logic             rampStop,
  output logic             dcBrakeOn,
  output logic      [6:0]  dcBrakeCurrent,
  output logic             searchActive,
  output logic      [15:0] searchStartFreq,
  output logic      [15:0] freqCommand,
  output logic             overheatWarn,
  output logic             overheatFault
);
  // Settings written by software
  logic [13:0] thermistorDebounceTime;  // 2 ms units
  logic [6:0]  thermistorTripLevel;     // Tenths of volts
  logic [6:0]  thermistorWarnLevel;     // Tenths of volts
  logic [5:0]  thermistorHysteresis;    // Tenths of volts
  logic [1:0]  thermistorTreatmentSelect;
  logic [6:0]  dcBrakeLevel;            // Percent of rated current
  logic [9:0]  dcBrakeStartTime;        // Tenths of seconds
  logic [9:0]  dcBrakeStopTime;         // Tenths of seconds
  logic [15:0] dcBrakeStartFrequency;   // Hundredths of hertz
  logic [1:0]  stopMethodSelect;
  logic [1:0]  powerLossActionSelect;
  logic [5:0]  powerLossMaxTime;        // Tenths of seconds
  logic [1:0]  blockSearchSelect;
  logic [5:0]  blockWaitTime;           // Tenths of seconds
  logic [7:0]  searchCurrentLimit;      // Percent
  logic [15:0] skipHigh [3];            // Band upper limits
  logic [15:0] skipLow  [3];            // Band lower limits
  logic [3:0]  faultRestartCount;
  logic [15:0] faultRestartRefillTime;  // Tenths of seconds

  // Two-flop synchronisers for every pin input
  logic [7:0] uvS1, uvS2;
  logic [6:0] aviS1, aviS2;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      uvS1  <= 8'h00;
      uvS2  <= 8'h00;
      aviS1 <= 7'h00;
      aviS2 <= 7'h00;
    end else begin
      uvS1  <= {runCommand, resetKey, undervoltageIndication, overloadTrip,
                externalBlock, overCurrentFault, overVoltageFault, 1'b0};
      uvS2  <= uvS1;
      aviS1 <= analogVoltageInput;
      aviS2 <= aviS1;
    end
  end
  logic runS, rstKeyS, uvS, olS, bbS, ocS, ovS;
  assign {runS, rstKeyS, uvS, olS, bbS, ocS, ovS} = uvS2[7:1];

  // APB slave: zero wait states, error on unmapped addresses
  logic mapped;
  assign pready = 1'b1;
  assign mapped = (paddr <= dprs_pkg::OFS_STATUS) && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !mapped;
  logic wrEn;
  assign wrEn = psel && penable && pwrite && mapped;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      thermistorDebounceTime    <= dprs_pkg::RST_DEB;
      thermistorTripLevel       <= dprs_pkg::RST_TRIP;
      thermistorWarnLevel       <= dprs_pkg::RST_WARN;
      thermistorHysteresis      <= dprs_pkg::RST_HYST;
      thermistorTreatmentSelect <= dprs_pkg::RST_TREAT;
      dcBrakeLevel              <= 7'h00;
      dcBrakeStartTime          <= 10'h000;
      dcBrakeStopTime           <= 10'h000;
      dcBrakeStartFrequency     <= 16'h0000;
      stopMethodSelect          <= 2'h0;
      powerLossActionSelect     <= 2'h0;
      powerLossMaxTime          <= dprs_pkg::RST_LOSS_T;
      blockSearchSelect         <= dprs_pkg::RST_BB_SEL;
      blockWaitTime             <= dprs_pkg::RST_BB_T;
      searchCurrentLimit        <= dprs_pkg::RST_SRCH_I;
      skipHigh                  <= '{3{16'h0000}};
      skipLow                   <= '{3{16'h0000}};
      faultRestartCount         <= 4'h0;
      faultRestartRefillTime    <= dprs_pkg::RST_REFILL;
    end else if (wrEn) begin
      case (paddr)
        dprs_pkg::OFS_THERM_DEB:  thermistorDebounceTime <= pwdata[13:0];
        dprs_pkg::OFS_THERM_LVL: begin
          thermistorTripLevel  <= pwdata[6:0];
          thermistorWarnLevel  <= pwdata[14:8];
          thermistorHysteresis <= pwdata[21:16];
        end
        dprs_pkg::OFS_THERM_CTL: begin
          thermistorTreatmentSelect <= pwdata[1:0];
          stopMethodSelect          <= pwdata[5:4];
        end
        dprs_pkg::OFS_BRAKE: begin
          // Levels above 100 percent are clamped
          dcBrakeLevel     <= (pwdata[6:0] > 7'h64) ? 7'h64 : pwdata[6:0];
          dcBrakeStartTime <= pwdata[17:8];
          dcBrakeStopTime  <= pwdata[29:20];
        end
        dprs_pkg::OFS_BRAKE_FREQ: dcBrakeStartFrequency <= pwdata[15:0];
        dprs_pkg::OFS_LOSS: begin
          powerLossActionSelect <= pwdata[1:0];
          powerLossMaxTime      <= pwdata[13:8];
        end
        dprs_pkg::OFS_SEARCH: begin
          blockSearchSelect  <= pwdata[1:0];
          blockWaitTime      <= pwdata[13:8];
          searchCurrentLimit <= pwdata[23:16];
        end
        dprs_pkg::OFS_SKIP1: {skipHigh[0], skipLow[0]} <= pwdata;
        dprs_pkg::OFS_SKIP2: {skipHigh[1], skipLow[1]} <= pwdata;
        dprs_pkg::OFS_SKIP3: {skipHigh[2], skipLow[2]} <= pwdata;
        dprs_pkg::OFS_RESTART: begin
          faultRestartCount      <= (pwdata[3:0] > 4'hA) ? 4'hA : pwdata[3:0];
          faultRestartRefillTime <= pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // Thermistor debounce: crossing state must hold for the whole period
  logic        tripRaw, warnRaw, tripDeb, warnDeb;
  // Prescaler is 17 bits so the full 2 ms unit at 50 MHz fits
  logic [16:0] debPre;
  logic [13:0] debCnt;
  assign tripRaw = aviS2 >= thermistorTripLevel;
  assign warnRaw = aviS2 >= thermistorWarnLevel;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      debPre  <= 17'h00000;
      debCnt  <= 14'h0000;
      tripDeb <= 1'b0;
      warnDeb <= 1'b0;
    end else if (tripRaw == tripDeb && warnRaw == warnDeb) begin
      debPre <= 17'h00000;
      debCnt <= 14'h0000;
    end else if (debCnt >= thermistorDebounceTime) begin
      tripDeb <= tripRaw;
      warnDeb <= warnRaw;
      debPre  <= 17'h00000;
      debCnt  <= 14'h0000;
    end else if (debPre == 17'(DEB_CYCLES - 1)) begin
      debPre <= 17'h00000;
      debCnt <= debCnt + 14'h0001;
    end else begin
      debPre <= debPre + 17'h00001;
    end
  end

  // Overheat latch with hysteresis on clearing
  logic [7:0] clearLevel;
  assign clearLevel = {1'b0, thermistorWarnLevel} -
                      {2'b00, thermistorHysteresis};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      overheatFault <= 1'b0;
    end else if (tripDeb) begin
      overheatFault <= 1'b1;
    end else if (rstKeyS &&
                 ($signed({1'b0, aviS2}) < $signed(clearLevel))) begin
      overheatFault <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) overheatWarn <= 1'b0;
    else       overheatWarn <= warnDeb || overheatFault;
  end

  // Tenth-second tick shared by the power-loss and restart refill timers
  logic [22:0] tickPre;
  logic        tick;
  assign tick = tickPre == 23'(TENTH_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)     tickPre <= 23'h000000;
    else if (tick) tickPre <= 23'h000000;
    else           tickPre <= tickPre + 23'h000001;
  end

  // Power-loss duration timer
  logic [5:0] lossTime;
  logic       lossTooLong, lossArmed, uvPrev;
  assign lossTooLong = lossTime >= powerLossMaxTime;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lossTime  <= 6'h00;
      lossArmed <= 1'b0;
      uvPrev    <= 1'b0;
    end else begin
      uvPrev <= uvS;
      if (!uvS) lossTime <= 6'h00;
      else if (tick && !lossTooLong) lossTime <= lossTime + 6'h01;
      lossArmed <= uvS && !olS && (powerLossMaxTime <= dprs_pkg::LOSS_LIMIT);
    end
  end

  // Skip bands: hold the last frequency outside every band
  logic [2:0]  inBand;
  logic [15:0] lastSafeFreq;
  for (genvar b = 0; b < 3; b++) begin : gBand
    assign inBand[b] = (skipHigh[b] != skipLow[b]) &&
                       (requestFreq >= skipLow[b]) &&
                       (requestFreq <= skipHigh[b]);
  end

  // Supervisor state machine
  // Local names for the package's state codes
  localparam dprs_pkg::dprs_state_type DP_IDLE = dprs_pkg::DP_IDLE;
  localparam dprs_pkg::dprs_state_type DP_STARTBRAKE = dprs_pkg::DP_STARTBRAKE;
  localparam dprs_pkg::dprs_state_type DP_RUN = dprs_pkg::DP_RUN;
  localparam dprs_pkg::dprs_state_type DP_STOPPING = dprs_pkg::DP_STOPPING;
  localparam dprs_pkg::dprs_state_type DP_STOPBRAKE = dprs_pkg::DP_STOPBRAKE;
  localparam dprs_pkg::dprs_state_type DP_BLOCKWAIT = dprs_pkg::DP_BLOCKWAIT;
  localparam dprs_pkg::dprs_state_type DP_SEARCH = dprs_pkg::DP_SEARCH;
  localparam dprs_pkg::dprs_state_type DP_FAULTED = dprs_pkg::DP_FAULTED;
  dprs_pkg::dprs_state_type state;
  logic [15:0] stateTime;
  logic [22:0] statePre;  // Restarts with stateTime, so no short first tenth
  logic [15:0] preFaultFreq;
  logic [3:0]  restartsLeft;
  logic [15:0] quietTime;
  logic        runPrev;
  logic        faultNow;
  assign faultNow = ocS || ovS;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state           <= DP_IDLE;
      stateTime       <= 16'h0000;
      statePre        <= 23'h000000;
      preFaultFreq    <= 16'h0000;
      searchStartFreq <= 16'h0000;
      runPrev         <= 1'b0;
      coastStop       <= 1'b0;
      rampStop        <= 1'b0;
    end else begin
      runPrev <= runS;
      // Private prescaler so a timed state lasts its full setting
      if (statePre == 23'(TENTH_CYCLES - 1)) begin
        statePre  <= 23'h000000;
        stateTime <= stateTime + 16'h0001;
      end else begin
        statePre <= statePre + 23'h000001;
      end
      case (state)
        DP_IDLE: begin
          coastStop <= 1'b0;
          rampStop  <= 1'b0;
          if (runS && !runPrev && !overheatFault) begin
            state     <= DP_STARTBRAKE;
            stateTime <= 16'h0000;
            statePre  <= 23'h000000;
          end
        end
        DP_STARTBRAKE: if (stateTime >= 16'(dcBrakeStartTime)) begin
          state <= DP_RUN;
        end
        DP_RUN: begin
          preFaultFreq <= outputFreq;
          if (tripDeb && thermistorTreatmentSelect != 2'h2) begin
            if (thermistorTreatmentSelect == 2'h0 && !overheatFault) begin
              rampStop <= 1'b1;
              state    <= DP_STOPPING;
            end else begin
              coastStop <= 1'b1;
              state     <= DP_FAULTED;
            end
          end else if (faultNow) begin
            coastStop <= (restartsLeft == 4'h0);
            state     <= (restartsLeft == 4'h0) ? DP_FAULTED : DP_BLOCKWAIT;
            searchStartFreq <= preFaultFreq; // pre-fault frequency
            stateTime <= 16'h0000;
            statePre  <= 23'h000000;
          end else if (uvS && !uvPrev && lossArmed) begin
            coastStop <= (powerLossActionSelect == 2'h0);
            state     <= (powerLossActionSelect == 2'h0) ? DP_FAULTED
                                                         : DP_BLOCKWAIT;
            searchStartFreq <= (powerLossActionSelect == 2'h1) ? masterFreq
                                                               : minFreq;
            stateTime <= 16'h0000;
            statePre  <= 23'h000000;
          end else if (bbS) begin
            state <= DP_BLOCKWAIT;
            searchStartFreq <= (blockSearchSelect == 2'h2) ? minFreq
                                                           : requestFreq;
            stateTime <= 16'h0000;
            statePre  <= 23'h000000;
          end else if (!runS) begin
            rampStop <= 1'b1;
            state    <= DP_STOPPING;
          end
        end
        DP_STOPPING: begin
          if (outputFreq <= dcBrakeStartFrequency) begin
            state     <= (stopMethodSelect == 2'h0 ||
                          stopMethodSelect == 2'h2) ? DP_STOPBRAKE : DP_IDLE;
            stateTime <= 16'h0000;
            statePre  <= 23'h000000;
          end
        end
        DP_STOPBRAKE: if (stateTime >= 16'(dcBrakeStopTime)) begin
          state <= overheatFault ? DP_FAULTED : DP_IDLE;
        end
        DP_BLOCKWAIT: begin
          if (uvS && lossTooLong) begin
            coastStop <= 1'b1;
            state     <= DP_FAULTED;
          // wait block time after undervoltage or external block ends
          end else if (uvS || bbS) begin
            stateTime <= 16'h0000;
            statePre  <= 23'h000000;
          end else if (stateTime >= 16'(blockWaitTime)) begin
            state <= (blockSearchSelect == 2'h0 && searchStartFreq ==
                      requestFreq && !faultNow) ? DP_RUN : DP_SEARCH;
          end
        end
        DP_SEARCH: if (outputCurrentPct < searchCurrentLimit) begin
          state <= DP_RUN;
        end
        DP_FAULTED: if (!overheatFault && rstKeyS) begin
          state <= DP_IDLE;
        end
        default: state <= DP_IDLE;
      endcase
    end
  end

  // Restart budget and quiet-period refill
  // count and refill
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      restartsLeft <= 4'h0;
      quietTime    <= 16'h0000;
    end else if (wrEn && paddr == dprs_pkg::OFS_RESTART) begin
      restartsLeft <= (pwdata[3:0] > 4'hA) ? 4'hA : pwdata[3:0];
      quietTime    <= 16'h0000;
    end else if (state == DP_RUN && faultNow && restartsLeft != 4'h0) begin
      restartsLeft <= restartsLeft - 4'h1;
      quietTime    <= 16'h0000;
    end else if (quietTime > faultRestartRefillTime) begin
      restartsLeft <= faultRestartCount;
    end else if (tick) begin
      quietTime <= quietTime + 16'h0001;
    end
  end

  // Modulator-facing outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      outputBlock    <= 1'b0;
      dcBrakeOn      <= 1'b0;
      dcBrakeCurrent <= 7'h00;
      searchActive   <= 1'b0;
      lastSafeFreq   <= 16'h0000;
      freqCommand    <= 16'h0000;
    end else begin
      outputBlock  <= state == DP_BLOCKWAIT || state == DP_FAULTED;
      searchActive <= state == DP_SEARCH;
      dcBrakeOn      <= state == DP_STARTBRAKE || state == DP_STOPBRAKE;
      dcBrakeCurrent <= (state == DP_STARTBRAKE || state == DP_STOPBRAKE)
                        ? dcBrakeLevel : 7'h00;
      if (inBand == 3'b000) lastSafeFreq <= requestFreq;
      if (state == DP_STARTBRAKE) freqCommand <= minFreq;
      else if (state == DP_SEARCH) freqCommand <= searchStartFreq;
      else if (inBand == 3'b000) freqCommand <= requestFreq;
      else freqCommand <= lastSafeFreq;
    end
  end

  // Status readback
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        dprs_pkg::OFS_THERM_DEB:  prdata <= {18'h0, thermistorDebounceTime};
        dprs_pkg::OFS_THERM_LVL:  prdata <= {10'h0, thermistorHysteresis,
          1'b0, thermistorWarnLevel, 1'b0, thermistorTripLevel};
        dprs_pkg::OFS_THERM_CTL:  prdata <= {26'h0, stopMethodSelect, 2'h0,
          thermistorTreatmentSelect};
        dprs_pkg::OFS_BRAKE:      prdata <= {2'h0, dcBrakeStopTime, 2'h0,
          dcBrakeStartTime, 1'b0, dcBrakeLevel};
        dprs_pkg::OFS_BRAKE_FREQ: prdata <= {16'h0, dcBrakeStartFrequency};
        dprs_pkg::OFS_LOSS:       prdata <= {18'h0, powerLossMaxTime, 6'h0,
          powerLossActionSelect};
        dprs_pkg::OFS_SEARCH:     prdata <= {8'h0, searchCurrentLimit, 2'h0,
          blockWaitTime, 6'h0, blockSearchSelect};
        dprs_pkg::OFS_SKIP1:      prdata <= {skipHigh[0], skipLow[0]};
        dprs_pkg::OFS_SKIP2:      prdata <= {skipHigh[1], skipLow[1]};
        dprs_pkg::OFS_SKIP3:      prdata <= {skipHigh[2], skipLow[2]};
        dprs_pkg::OFS_RESTART:    prdata <= {faultRestartRefillTime, 8'h0,
          restartsLeft, faultRestartCount};
        dprs_pkg::OFS_STATUS:     prdata <= {24'h0, 1'b0, state,
          overheatFault, overheatWarn, tripDeb, warnDeb};
        default:                  prdata <= 32'h00000000;
      endcase
    end
  end

  // Checks, all on the one system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  brake_level_a: assert property (
    dcBrakeOn |-> dcBrakeCurrent == dcBrakeLevel)
    else $error("brake current differs from level");
  trip_latch_a: assert property (
    tripDeb |=> overheatFault)
    else $error("overheat fault not latched");
  block_wait_a: assert property (
    (state == DP_BLOCKWAIT) |=> outputBlock)
    else $error("output not blocked during wait");
  skip_hold_a: assert property (
    (state == DP_RUN && inBand != 3'b000) |=>
    freqCommand == $past(lastSafeFreq))
    else $error("frequency entered skip band");
  restart_cap_a: assert property (
    restartsLeft <= 4'hA)
    else $error("restart count above ten");
  stop_brake_a: assert property (
    (state == DP_STOPBRAKE) |-> (stopMethodSelect == 2'h0 ||
     stopMethodSelect == 2'h2 || $past(state) == DP_STOPBRAKE))
    else $error("stop brake with coast method");
  search_exit_a: assert property (
    (state == DP_SEARCH && outputCurrentPct < searchCurrentLimit) |=>
    state == DP_RUN)
    else $error("search did not end");
  start_min_a: assert property (
    (state == DP_STARTBRAKE) |=> freqCommand == $past(minFreq))
    else $error("start brake not at minimum frequency");
endmodule

// File: dprs_plant_model.sv
// Power stage stand-in: output current and output frequency.
// Assumes the supervisor's frequency command and search flag.
`timescale 1ns/1ps
module dprs_plant_model (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        outputBlock,
  input  wire logic        searchActive,
  input  wire logic [15:0] freqCommand,
  output logic      [7:0]  outputCurrentPct,
  output logic      [15:0] outputFreq
);
  // Search current starts high and decays as the rotor is caught
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      outputCurrentPct <= 8'h00;
      outputFreq       <= 16'h0000;
    end else begin
      // Output frequency lags the command by one cycle
      outputFreq <= outputBlock ? 16'h0000 : freqCommand;
      if (outputBlock) begin
        outputCurrentPct <= 8'h00;
      end else if (searchActive) begin
        outputCurrentPct <= (outputCurrentPct == 8'h00) ? 8'hC8 :
                            outputCurrentPct - 8'h01;
      end else begin
        outputCurrentPct <= 8'h50;
      end
    end
  end
endmodule

// File: tb_drive_protect_restart_supervisor.sv
// Random and corner tests of the supervisor over APB.
// Assumes 10 cycles per tenth second and 4 per debounce unit.
`timescale 1ns/1ps
module tb_drive_protect_restart_supervisor;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, outputBlock, coastStop, rampStop;
  logic        dcBrakeOn, searchActive, overheatWarn, overheatFault;
  logic        runCommand = 1'b0, resetKey = 1'b0, overloadTrip = 1'b0;
  logic        undervoltageIndication = 1'b0, externalBlock = 1'b0;
  logic        overCurrentFault = 1'b0, overVoltageFault = 1'b0;
  logic [6:0]  analogVoltageInput = 7'h00, dcBrakeCurrent;
  logic [7:0]  outputCurrentPct;
  logic [15:0] outputFreq, searchStartFreq, freqCommand;
  logic [15:0] masterFreq = 16'h1388, minFreq = 16'h01F4;
  logic [15:0] requestFreq = 16'h0000, up [3], lo [3];
  int          failures = 0, checked = 0, k, b;
  // Clock at 50 MHz
  always #10 sys_clk = ~sys_clk;
  dprs_supervisor #(.TENTH_CYCLES(10), .DEB_CYCLES(4)) dut (.*);
  dprs_plant_model plant (.*);
  // Verdict and end of run
  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Hang guard: far beyond the expected test length
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run;
  end
  initial begin
    void'($urandom(56491));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("debounce", 32'h64, q);
    apb(1'b0, 8'h04, 32'h0);
    // Default trip level sits above the warning level
    chk("levels", 32'h00060C18, q);
    apb(1'b0, 8'h18, 32'h0);
    chk("search", 32'h00960501, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("loss", 32'h00001400, q);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("defaults done");
    apb(1'b1, 8'h0C, 32'h0000027F);
    apb(1'b0, 8'h0C, 32'h0);
    chk("brake clamp", 32'h00000264, q);
    // Bands kept non-increasing by the programmer
    up[0] = 16'(50000 - $urandom_range(0, 5000));
    for (b = 0; b < 3; b++) begin
      if (b > 0) up[b] = 16'(lo[b-1] - $urandom_range(0, 1000));
      lo[b] = 16'(up[b] - $urandom_range(200, 2000));
      apb(1'b1, 8'(8'h1C + 4 * b), {up[b], lo[b]});
      apb(1'b0, 8'(8'h1C + 4 * b), 32'h0);
      chk("band", {up[b], lo[b]}, q);
    end
    requestFreq <= 16'(lo[0] + (up[0] - lo[0]) / 2);
    apb(1'b1, 8'h0C, 32'h00000232);
    @(posedge sys_clk);
    runCommand <= 1'b1;
    for (k = 0; k < 20 && dcBrakeOn !== 1'b1; k++) @(posedge sys_clk);
    chk("brake on", 32'h1, {31'h0, dcBrakeOn});
    chk("brake level", 32'h32, {25'h0, dcBrakeCurrent});
    for (k = 0; k < 60 && dcBrakeOn === 1'b1; k++) @(posedge sys_clk);
    chk("brake time", 32'h1, {31'h0, k >= 18 && k <= 22});
    repeat (200) @(posedge sys_clk);
    for (b = 0; b < 3; b++)
      chk("skip", 32'h0, {31'h0, freqCommand > lo[b] &&
                          freqCommand < up[b]});
    $display("run done");
    apb(1'b1, 8'h08, 32'h00000002);
    apb(1'b1, 8'h00, 32'h00000002);
    analogVoltageInput <= 7'h10;
    repeat (5) @(posedge sys_clk);
    chk("warn early", 32'h0, {31'h0, overheatWarn});
    for (k = 0; k < 30 && overheatWarn !== 1'b1; k++) @(posedge sys_clk);
    chk("warn", 32'h1, {31'h0, overheatWarn});
    analogVoltageInput <= 7'h20;
    repeat (3) @(posedge sys_clk);
    analogVoltageInput <= 7'h10;
    repeat (30) @(posedge sys_clk);
    chk("short trip", 32'h0, {31'h0, overheatFault});
    analogVoltageInput <= 7'h20;
    for (k = 0; k < 30 && overheatFault !== 1'b1; k++) @(posedge sys_clk);
    chk("trip", 32'h1, {31'h0, overheatFault});
    analogVoltageInput <= 7'h07;
    repeat (20) @(posedge sys_clk);
    resetKey <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("no clear", 32'h1, {31'h0, overheatFault});
    analogVoltageInput <= 7'h05;
    repeat (30) @(posedge sys_clk);
    chk("clear", 32'h0, {31'h0, overheatFault});
    $display("thermistor done");
    complete_run;
  end
endmodule
